// ---- jtt_pkg.sv ----
// jtt_pkg: shared constants, state codes and carriers for the test port host
`default_nettype none

package jtt_pkg;

   // ------------------------------
   // clocking and timing
   // ------------------------------
   localparam int CLK_PERIOD_NS  = 5;     // clk_sys period
   localparam int TCK_HALF_DEF   = 5;     // clk_sys cycles per tck half
   localparam int TCK_HALF_MIN   = 4;     // tdo sync latency plus margin
   localparam int RST_HOLD_NS    = 1000;  // system reset pulse length
   localparam int RST_HOLD_CYC   =
      (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------
   // scan geometry
   // ------------------------------
   localparam int DATA_W         = 32;    // longest data scan
   localparam int LEN_W          = 6;     // width of a bit count
   localparam int IR_LEN         = 4;     // instruction length
   localparam logic [3:0] IR_CAPTURE = 4'h1; // value shifted out of IR
   localparam logic [2:0] RESET_ONES = 3'h5; // tms-high periods to reset

   // ------------------------------
   // state codes
   // ------------------------------
   typedef enum logic [3:0] {
      TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2,
      TAP_CAP_DR = 4'h3, TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5,
      TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7, TAP_UP_DR  = 4'h8,
      TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
      TAP_EX1_IR = 4'hC, TAP_PA_IR  = 4'hD, TAP_EX2_IR = 4'hE,
      TAP_UP_IR  = 4'hF
   } jtt_tap_t;

   typedef enum logic [1:0] {
      CMD_TAP_RESET = 2'h0,   // five tms-high periods, then idle
      CMD_IR_SCAN   = 2'h1,   // load a 4-bit instruction
      CMD_DR_SCAN   = 2'h2,   // scan len bits of the selected register
      CMD_SYS_RESET = 2'h3    // pull the system reset line low
   } jtt_kind_t;

   typedef struct packed {
      jtt_kind_t          kind;
      logic [LEN_W-1:0]   len;    // 0 or above DATA_W means DATA_W
      logic [DATA_W-1:0]  data;   // bit 0 goes out first
   } jtt_cmd_t;

   typedef struct packed {
      logic [DATA_W-1:0]  data;   // captured bits, right aligned
      logic               irBad;  // ir capture was not the fixed pattern
   } jtt_rsp_t;

   // next state of the device's controller for a tms value at rising tck
   function automatic jtt_tap_t tap_next(jtt_tap_t s, logic tms);
      unique case (s)
         TAP_RESET:  return tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   return tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: return tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: return tms ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  return tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: return tms ? TAP_UP_DR  : TAP_SH_DR;
         TAP_UP_DR:  return tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: return tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: return tms ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  return tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: return tms ? TAP_UP_IR  : TAP_SH_IR;
         TAP_UP_IR:  return tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction

endpackage

`default_nettype wire

// ---- jtt_sync2.sv ----
// jtt_sync2: two-flop synchroniser for pin inputs
`default_nettype none

module jtt_sync2 #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input  wire logic         clk,     // destination clock
   input  wire logic         rstN,    // async reset, active low
   input  wire logic [W-1:0] din,     // asynchronous input
   output logic      [W-1:0] dout     // synchronised copy
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] out_next;

   // ------------------------------------------------------------------
   // first stage is read only by the second
   // ------------------------------------------------------------------
   always_comb begin
      meta_next = din;
      out_next  = meta_reg;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_reg <= INIT;
         dout     <= INIT;
      end else begin
         meta_reg <= meta_next;
         dout     <= out_next;
      end
   end

endmodule

`default_nettype wire

// ---- jtt_tck_gen.sv ----
// jtt_tck_gen: divides clk_sys into the test clock and marks its edges
`default_nettype none

module jtt_tck_gen #(
   parameter int HALF = 5
) (
   input  wire logic clk,       // system clock
   input  wire logic rstN,      // synchronised reset, active low
   output logic      tck,       // test clock, starts low
   output logic      riseEv,    // pulse with the rising tck edge
   output logic      fallEv     // pulse with the falling tck edge
);

   localparam int CW = $clog2(HALF + 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tck_next;
   logic          rise_next;
   logic          fall_next;

   // ------------------------------------------------------------------
   // free running divider; events coincide with the pin change
   // ------------------------------------------------------------------
   always_comb begin
      cnt_next  = cnt_reg + CW'(1);
      tck_next  = tck;
      rise_next = 1'b0;
      fall_next = 1'b0;
      if (cnt_reg == CW'(HALF - 1)) begin
         cnt_next  = '0;
         tck_next  = ~tck;
         rise_next = ~tck;
         fall_next = tck;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cnt_reg <= '0;
         tck     <= 1'b0;
         riseEv  <= 1'b0;
         fallEv  <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tck     <= tck_next;
         riseEv  <= rise_next;
         fallEv  <= fall_next;
      end
   end

endmodule

`default_nettype wire

// ---- jtt_host.sv ----
// jtt_host: host that drives a device's four-pin test access port
//
// Overview of operation
// - five tms-high periods reach Test-Logic-Reset from any state.
// - scans shift least significant bit first.
// - from idle, tms 1,1,0,0 reaches Shift-IR.
// - tms low for three instruction bits, high with the last.
// - tms 1,1,0 returns to idle; Update-IR applies the instruction.
// - from idle, tms 1,0,0 reaches Shift-DR.
// - data shifts with tms low, high with the last bit.
// - data scan may follow Update-IR directly; this host always returns to idle first.
// - tdo floats outside shift states; system pulls it up.
// - debugger watches system reset, may pull it low.
`default_nettype none

module jtt_host
   import jtt_pkg::*;
#(
   parameter int TCK_HALF = TCK_HALF_DEF,  // clk_sys cycles per tck half
   parameter int RST_HOLD = RST_HOLD_CYC   // system reset pulse, cycles
) (
   input  wire logic     clk_sys,     // system clock, 200 MHz
   input  wire logic     rst_b,       // async reset, active low
   input  wire logic     cmdValid,    // command offered
   input  wire jtt_cmd_t cmd,         // command contents
   output logic          cmdReady,    // host can take a command
   output logic          rspValid,    // one-cycle result pulse
   output jtt_rsp_t      rsp,         // result of the last command
   output logic          busy,        // command in progress
   output jtt_tap_t      tapState,    // mirrored device controller state
   output logic          tck,         // test clock to device
   output logic          tms,         // mode select to device
   output logic          tdi,         // serial data to device
   input  wire logic     tdo,         // serial data from device
   input  wire logic     sysRstIn,    // level seen on system reset line
   output logic          sysRstOut,   // drive value, always low
   output logic          sysRstOe,    // high while pulling reset low
   output logic          sysRstSeen   // system reset line is low
);

   // ------------------------------
   // elaboration checks
   // ------------------------------
   if (TCK_HALF < TCK_HALF_MIN) begin : g_half_chk
      $error("TCK_HALF too small for the tdo synchroniser");
   end
   if (RST_HOLD < 1 || RST_HOLD > 65535) begin : g_hold_chk
      $error("RST_HOLD out of range");
   end
   if (DATA_W >= (1 << LEN_W)) begin : g_len_chk
      $error("LEN_W cannot count DATA_W bits");
   end

   typedef enum logic [1:0] {
      H_IDLE   = 2'h0,
      H_RESET  = 2'h1,
      H_SCAN   = 2'h2,
      H_SYSRST = 2'h3
   } jtt_host_t;

   // ------------------------------
   // reset release
   // ------------------------------
   logic [1:0] rstSync_reg;
   logic       rstN;

   // async assert, two-flop release so no flop leaves reset mid-cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end
   assign rstN = rstSync_reg[1];

   // ------------------------------
   // test clock and pin inputs
   // ------------------------------
   logic       riseEv;
   logic       fallEv;
   logic [1:0] pinSync;
   logic       tdoS;
   logic       sysRstS;

   // tck is made here from clk_sys, so the link stays in one domain
   jtt_tck_gen #(
      .HALF   (TCK_HALF)
   ) u_tck (
      .clk    (clk_sys),
      .rstN   (rstN),
      .tck    (tck),
      .riseEv (riseEv),
      .fallEv (fallEv)
   );

   // idle level of both lines is high, matching their pull-ups
   jtt_sync2 #(
      .W    (2),
      .INIT (2'h3)
   ) u_sync (
      .clk  (clk_sys),
      .rstN (rstN),
      .din  ({sysRstIn, tdo}),
      .dout (pinSync)
   );
   assign tdoS    = pinSync[0];
   assign sysRstS = pinSync[1];

   // ------------------------------
   // sequencer state
   // ------------------------------
   jtt_host_t         host_reg,    host_next;
   jtt_tap_t          tap_next_s;
   jtt_kind_t         kind_reg,    kind_next;
   logic              tms_next,    tdi_next;
   logic [DATA_W-1:0] tx_reg,      tx_next;
   logic [DATA_W-1:0] rx_reg,      rx_next;
   logic [LEN_W-1:0]  left_reg,    left_next;
   logic [LEN_W-1:0]  len_reg,     len_next;
   logic [2:0]        ones_reg,    ones_next;
   logic [15:0]       hold_reg,    hold_next;
   logic              pend_reg,    pend_next;
   logic              ready_next,  rspV_next;
   jtt_rsp_t          rsp_next;
   logic              oe_next,     seen_next;
   logic [LEN_W-1:0]  effLen;
   logic              accept;
   logic              inShift;

   // a zero or oversized length means a full-width scan
   assign effLen = (cmd.len == '0 || cmd.len > LEN_W'(DATA_W))
                   ? LEN_W'(DATA_W) : cmd.len;
   assign accept = cmdValid && cmdReady && host_reg == H_IDLE;
   // tdo is only meaningful in a shift state; elsewhere it floats
   assign inShift = tapState == TAP_SH_DR || tapState == TAP_SH_IR;

   // tms the host applies at the next falling edge while scanning
   function automatic logic scan_tms(jtt_tap_t s, jtt_kind_t k,
                                     logic [LEN_W-1:0] left);
      unique case (s)
         TAP_RESET:  return 1'b0;                   // into idle
         TAP_IDLE:   return 1'b1;
         TAP_SEL_DR: return k == CMD_IR_SCAN;
         TAP_SEL_IR: return 1'b0;
         TAP_CAP_DR,
         TAP_CAP_IR: return 1'b0;                   // enter shift
         TAP_SH_DR,
         TAP_SH_IR:  return left == LEN_W'(1);
         TAP_EX1_DR,
         TAP_EX1_IR,
         TAP_PA_DR,
         TAP_PA_IR,
         TAP_EX2_DR,
         TAP_EX2_IR: return 1'b1;
         TAP_UP_DR,
         TAP_UP_IR:  return 1'b0;
      endcase
   endfunction

   // ------------------------------
   // next-state logic
   // ------------------------------
   always_comb begin
      host_next  = host_reg;
      kind_next  = kind_reg;
      tms_next   = tms;
      tdi_next   = tdi;
      tx_next    = tx_reg;
      rx_next    = rx_reg;
      left_next  = left_reg;
      len_next   = len_reg;
      ones_next  = ones_reg;
      hold_next  = hold_reg;
      pend_next  = pend_reg;
      rspV_next  = 1'b0;
      rsp_next   = rsp;
      oe_next    = sysRstOe;
      seen_next  = ~sysRstS;
      tap_next_s = tapState;
      // the mirror follows every rising edge, idle or not
      if (riseEv) begin
         tap_next_s = tap_next(tapState, tms);
      end

      unique case (host_reg)
         H_IDLE: begin
            if (fallEv) begin
               tms_next = 1'b0;
            end
            if (accept) begin
               kind_next = cmd.kind;
               tx_next   = cmd.data;
               rx_next   = '0;
               pend_next = 1'b1;
               unique case (cmd.kind)
                  CMD_TAP_RESET: begin
                     ones_next = 3'h0;
                     host_next = H_RESET;
                  end
                  CMD_IR_SCAN: begin
                     left_next = LEN_W'(IR_LEN);
                     len_next  = LEN_W'(IR_LEN);
                     host_next = H_SCAN;
                  end
                  CMD_DR_SCAN: begin
                     left_next = effLen;
                     len_next  = effLen;
                     host_next = H_SCAN;
                  end
                  CMD_SYS_RESET: begin
                     hold_next = 16'h0000;
                     oe_next   = 1'b1;
                     host_next = H_SYSRST;
                  end
               endcase
            end
         end

         H_RESET: begin
            // no reset pin exists, so tms is the only way back
            if (fallEv) begin
               tms_next = ones_reg < RESET_ONES;
            end
            if (riseEv) begin
               if (tms && ones_reg < RESET_ONES) begin
                  ones_next = ones_reg + 3'h1;
               end else if (!tms && ones_reg == RESET_ONES) begin
                  host_next = H_IDLE;
                  rspV_next = pend_reg;
                  pend_next = 1'b0;
                  rsp_next  = '0;
               end
            end
         end

         H_SCAN: begin
            if (fallEv) begin
               tms_next = scan_tms(tapState, kind_reg, left_reg);
               tdi_next = tx_reg[0];
            end
            if (riseEv) begin
               if (inShift) begin
                  // tdo moved at the falling edge, stable now
                  rx_next   = {tdoS, rx_reg[DATA_W-1:1]};
                  tx_next   = {1'b0, tx_reg[DATA_W-1:1]};
                  left_next = left_reg - LEN_W'(1);
               end
               // results are reported once the update edge has passed
               if ((tapState == TAP_UP_IR || tapState == TAP_UP_DR)
                   && !tms) begin
                  host_next    = H_IDLE;
                  rspV_next    = 1'b1;
                  pend_next    = 1'b0;
                  rsp_next.data = rx_reg >> (LEN_W'(DATA_W) - len_reg);
                  rsp_next.irBad = kind_reg == CMD_IR_SCAN &&
                     rx_reg[DATA_W-1 -: IR_LEN] != IR_CAPTURE;
               end
            end
         end

         H_SYSRST: begin
            if (fallEv) begin
               tms_next = 1'b0;
            end
            if (hold_reg == 16'(RST_HOLD - 1)) begin
               oe_next   = 1'b0;
               host_next = H_IDLE;
               rspV_next = 1'b1;
               pend_next = 1'b0;
               rsp_next  = '0;
            end else begin
               hold_next = hold_reg + 16'h0001;
            end
         end
      endcase

      ready_next = host_next == H_IDLE && !accept;
   end

   // ------------------------------
   // registers
   // ------------------------------
   // after reset the device state is unknown, so a tms reset runs first
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         host_reg   <= H_RESET;
         tapState   <= TAP_RESET;
         kind_reg   <= CMD_TAP_RESET;
         tms        <= 1'b1;
         tdi        <= 1'b1;
         tx_reg     <= '0;
         rx_reg     <= '0;
         left_reg   <= '0;
         len_reg    <= LEN_W'(IR_LEN);
         ones_reg   <= 3'h0;
         hold_reg   <= 16'h0000;
         pend_reg   <= 1'b0;
         cmdReady   <= 1'b0;
         rspValid   <= 1'b0;
         rsp        <= '0;
         sysRstOe   <= 1'b0;
         sysRstSeen <= 1'b0;
         busy       <= 1'b1;
         sysRstOut  <= 1'b0;
      end else begin
         host_reg   <= host_next;
         tapState   <= tap_next_s;
         kind_reg   <= kind_next;
         tms        <= tms_next;
         tdi        <= tdi_next;
         tx_reg     <= tx_next;
         rx_reg     <= rx_next;
         left_reg   <= left_next;
         len_reg    <= len_next;
         ones_reg   <= ones_next;
         hold_reg   <= hold_next;
         pend_reg   <= pend_next;
         cmdReady   <= ready_next;
         rspValid   <= rspV_next;
         rsp        <= rsp_next;
         sysRstOe   <= oe_next;
         sysRstSeen <= seen_next;
         busy       <= host_next != H_IDLE;
         sysRstOut  <= 1'b0;                        // open drain, low only
      end
   end

endmodule

`default_nettype wire

// ---- jtt_host_assertions.sv ----
// jtt_host_assertions: port checker bound to the test port host
`default_nettype none
module jtt_host_chk
   import jtt_pkg::*;
#(
   parameter int TCK_HALF = TCK_HALF_DEF,
   parameter int RST_HOLD = RST_HOLD_CYC
) (
   input wire logic     clk_sys,    // system clock
   input wire logic     rst_b,      // reset, active low
   input wire logic     cmdValid,   // command offered
   input wire jtt_cmd_t cmd,        // command
   input wire logic     cmdReady,   // host idle
   input wire logic     rspValid,   // result pulse
   input wire jtt_rsp_t rsp,        // result
   input wire logic     busy,       // running
   input wire jtt_tap_t tapState,   // mirrored state
   input wire logic     tck,        // test clock
   input wire logic     tms,        // mode select
   input wire logic     tdi,        // serial out
   input wire logic     tdo,        // serial in
   input wire logic     sysRstIn,   // reset line level
   input wire logic     sysRstOut,  // drive value
   input wire logic     sysRstOe,   // drive enable
   input wire logic     sysRstSeen  // line seen low
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // helper counters
   // ------------------------------------------------------------
   logic       tckQ;     // tck one cycle ago
   logic [2:0] oneCnt;   // tms-high rises in a row, saturates at 5
   logic [8:0] oeCnt;    // cycles the reset line has been pulled
   wire logic  tckRise = tck && !tckQ;

   // counters restart on reset so a second reset starts clean
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tckQ   <= 1'h0;
         oneCnt <= 3'h0;
         oeCnt  <= 9'h000;
      end else begin
         tckQ  <= tck;
         oeCnt <= sysRstOe ? oeCnt + 9'h001 : 9'h000;
         if (tckRise)
            oneCnt <= !tms ? 3'h0 : (oneCnt == 3'h5 ? 3'h5 : oneCnt + 3'h1);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_pins_hold_high: assert property (
      tck |-> $stable(tms) && $stable(tdi))
      else $error("tms or tdi moved while tck high");
   a_five_ones_reset: assert property (
      tckRise && tms && oneCnt >= 3'h4 |-> ##[0:4] tapState == TAP_RESET)
      else $error("five tms-high rises did not reach reset");
   a_rsp_single: assert property (
      rspValid |=> !rspValid && cmdReady)
      else $error("result pulse wrong");
   a_ready_idle: assert property (
      cmdReady |-> !busy && tapState == TAP_IDLE)
      else $error("ready outside idle");
   a_taken_drops: assert property (
      cmdValid && cmdReady |=> !cmdReady && busy)
      else $error("command not taken");
   a_oe_length: assert property (
      $fell(sysRstOe) |-> oeCnt == 9'(RST_HOLD))
      else $error("reset pull length wrong");
   a_oe_low: assert property (
      sysRstOe |-> !sysRstOut && busy)
      else $error("reset pull not low");
   a_seen_low: assert property (
      !sysRstIn [*5] |-> sysRstSeen)
      else $error("low reset line not seen");
   a_seen_high: assert property (
      sysRstIn [*5] |-> !sysRstSeen)
      else $error("high reset line seen low");
   a_tck_half: assert property (
      $rose(tck) |-> tck [*5] ##1 !tck)
      else $error("tck high phase wrong");

   c_ir_ok: cover property (rspValid && !rsp.irBad);
   c_sys_pull: cover property ($fell(sysRstOe));
   c_dr_shift: cover property (tapState == TAP_SH_DR);
endmodule

bind jtt_host jtt_host_chk #(.TCK_HALF(TCK_HALF), .RST_HOLD(RST_HOLD)) uChk (
   .clk_sys(clk_sys), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
   .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp), .busy(busy),
   .tapState(tapState), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
   .sysRstIn(sysRstIn), .sysRstOut(sysRstOut), .sysRstOe(sysRstOe),
   .sysRstSeen(sysRstSeen));
`default_nettype wire

// ---- jtt_dev_model.sv ----
// jtt_dev_model: behavioural test access port of the device
`default_nettype none
module jtt_dev_model
   import jtt_pkg::*;
#(
   parameter logic [31:0] ID_WORD  = 32'h1357_9BDF, // arbitrary value
   parameter logic [3:0]  OP_ID    = 4'h1,  // identification select
   parameter logic [3:0]  OP_LATCH = 4'h4,  // latched 8-bit register
   parameter logic TEST_PORT_ENABLE_FUSE = 1'h1,  // programmed
   parameter logic TEST_PORT_DISABLE_BIT = 1'h0   // clear
) (
   input  wire logic tck,   // test clock
   input  wire logic tms,   // mode select, host drives it
   input  wire logic tdi,   // serial in, host drives it
   output logic      tdo,   // serial out, pulled up when released
   output jtt_tap_t  st     // controller state
);
   timeunit 1ns;
   timeprecision 100ps;
   // next-state tables, one nibble per state code
   localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
   localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
   // pull-ups never show here because the host always drives tms and tdi
   wire logic portOn = TEST_PORT_ENABLE_FUSE && !TEST_PORT_DISABLE_BIT;
   logic [3:0]  ir    = OP_ID;
   logic [31:0] sr    = 32'h0;   // shift path
   logic [7:0]  latch = 8'h00;   // parallel output of the latched register
   // no test reset pin: only power-on, tms and a disabled port bring reset
   wire logic [5:0] drLen = (ir == OP_ID) ? 6'h20 :
                            (ir == OP_LATCH) ? 6'h08 : 6'h01;
   wire logic [5:0] pathLen = (st == TAP_SH_IR) ? 6'h04 : drLen;
   initial st = TAP_RESET;
   initial tdo = 1'h1;

   // controller and registers move on rising tck only
   always @(posedge tck) begin
      if (!portOn) begin
         st <= TAP_RESET;
      end else begin
         st <= jtt_tap_t'(tms ? NXT1[4*st+:4] : NXT0[4*st+:4]);
         case (st)
            TAP_RESET:  ir <= OP_ID;
            TAP_CAP_IR: sr <= 32'(IR_CAPTURE);
            TAP_CAP_DR: sr <= (ir == OP_ID) ? ID_WORD :
                              (ir == OP_LATCH) ? 32'(latch) : 32'h0;
            TAP_SH_IR, TAP_SH_DR: begin
               sr <= sr >> 1;
               sr[pathLen - 6'h01] <= tdi;
            end
            TAP_UP_IR:  ir <= sr[3:0];
            TAP_UP_DR:  if (ir == OP_LATCH) latch <= sr[7:0];
            default: ;
         endcase
      end
   end

   // tdo moves on falling tck and is released outside shifting
   always @(negedge tck)
      tdo <= (st inside {TAP_SH_IR, TAP_SH_DR}) ? sr[0] : '1;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the test port host and a device model
`default_nettype none
module tb_top import jtt_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ID_WORD = 32'h1357_9BDF; // arbitrary value
   localparam logic [3:0] OP_ID = 4'h1, OP_LATCH = 4'h4, OP_BYP = 4'hF;
   typedef struct packed {
      jtt_kind_t k; logic [5:0] n; logic [31:0] d; logic [31:0] e;
   } jtt_row_t;
   logic clk_sys = 1'h0, rst_b = 1'h0, cmdValid = 1'h0, extRstLow = 1'h0;
   logic cmdReady, rspValid, busy, tck, tms, tdi, tdo;
   logic sysRstOut, sysRstOe, sysRstSeen;
   jtt_cmd_t cmd = '0;
   jtt_rsp_t rsp, got;
   jtt_tap_t tapState, devSt;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   wire logic sysRstIn = !(sysRstOe || extRstLow); // pulled-up shared line
   // bypass returns its captured 0 first, so data comes back one bit up
   jtt_row_t rows [10] = '{
      '{CMD_DR_SCAN, 6'h20, 32'h0, ID_WORD},
      '{CMD_IR_SCAN, 6'h04, 32'(OP_BYP), 32'h1},
      '{CMD_DR_SCAN, 6'h08, 32'hA5, 32'h4A},
      '{CMD_IR_SCAN, 6'h04, 32'(OP_LATCH), 32'h1},
      '{CMD_DR_SCAN, 6'h08, 32'hA5, 32'h00},
      '{CMD_DR_SCAN, 6'h08, 32'h3C, 32'hA5},
      '{CMD_TAP_RESET, 6'h00, 32'h0, 32'h0},
      '{CMD_DR_SCAN, 6'h00, 32'h0, ID_WORD},
      '{CMD_IR_SCAN, 6'h04, 32'(OP_LATCH), 32'h1},
      '{CMD_DR_SCAN, 6'h08, 32'h00, 32'h3C}};

   jtt_host #(.TCK_HALF(5), .RST_HOLD(8)) DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp), .busy(busy),
      .tapState(tapState), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .sysRstIn(sysRstIn), .sysRstOut(sysRstOut), .sysRstOe(sysRstOe),
      .sysRstSeen(sysRstSeen));
   jtt_dev_model #(.ID_WORD(ID_WORD), .OP_ID(OP_ID), .OP_LATCH(OP_LATCH))
      uDev (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .st(devSt));

   initial forever #2.5 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] act, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (act !== exp) begin
         n_errors++;
         $display("FAIL %0t %s: got %h want %h", $time, what, act, exp);
      end
   endtask

   // offer only while ready, hold for one cycle, then wait for the pulse
   task automatic run(input jtt_kind_t k, input logic [5:0] n,
                      input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_sys);
      while (cmdReady !== 1'h1 && t < 3000) begin
         @(posedge clk_sys);
         t++;
      end
      cmdValid <= 1'h1;
      cmd <= '{kind: k, len: n, data: d};
      @(posedge clk_sys);
      cmdValid <= 1'h0;
      do begin
         @(posedge clk_sys);
         t++;
      end while (rspValid !== 1'h1 && t < 6000);
      got = rsp;
      check(32'(t < 6000), 32'h1, "no answer");
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // a hang counts as a mismatch and closes the run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         $display("FAIL %0t timeout", $time);
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'h1;
      foreach (rows[i]) begin
         run(rows[i].k, rows[i].n, rows[i].d);
         check(32'(tapState), 32'(devSt), "state mirror");
         if (rows[i].k inside {CMD_IR_SCAN, CMD_DR_SCAN})
            check(got.data, rows[i].e, "scan data");
         if (rows[i].k == CMD_IR_SCAN)
            check(32'(got.irBad), 32'h0, "ir capture");
      end
      // system reset pull, then an outside source pulling the line
      fork
         run(CMD_SYS_RESET, 6'h00, 32'h0);
         begin
            wait (sysRstOe === 1'h1);
            repeat (4) @(posedge clk_sys);
            check(32'(sysRstSeen), 32'h1, "pull seen");
         end
      join
      check(32'(sysRstOe), 32'h0, "line released");
      extRstLow <= 1'h1;
      repeat (6) @(posedge clk_sys);
      check(32'({sysRstSeen, sysRstOe}), 32'h2, "outside pull");
      extRstLow <= 1'h0;
      // second reset mid-run: the boot tms sequence restores the id select
      run(CMD_IR_SCAN, 6'h04, 32'(OP_LATCH));
      rst_b <= 1'h0;
      repeat (2) @(posedge clk_sys);
      check(32'({tck, tms, busy, cmdReady}), 32'h6, "in reset");
      rst_b <= 1'h1;
      run(CMD_DR_SCAN, 6'h20, 32'h0);
      check(got.data, ID_WORD, "id after reset");
      complete_run();
   end
endmodule
`default_nettype wire
